/* assc_baud_gen.sv */
// baud generator: one tick per sixteenth of a bit
`include "assc_defines.svh"

module assc_baud_gen
  import assc_pkg::*;
#(
  parameter int RELOAD_W = `ASSC_RELOAD_W
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  assc_baud_if.gen  bi
);
  if (RELOAD_W < 1 || RELOAD_W > `ASSC_RELOAD_W)
  begin : g_chk
    $error("reload width out of range");
  end

  logic [1:0]          pre_reg;
  logic [RELOAD_W-1:0] cnt_reg;
  logic                tick_reg;

  wire pre_end = bi.presc ? (pre_reg == `ASSC_PRE_3) : (pre_reg == `ASSC_PRE_2);
  wire cnt_end = (cnt_reg == '0);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pre_reg  <= 2'h0;
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else if (!bi.run)
    begin
      pre_reg  <= 2'h0;
      cnt_reg  <= bi.reload;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= pre_end & cnt_end; // R01
      pre_reg  <= pre_end ? 2'h0 : 2'(pre_reg + 2'h1);
      if (pre_end)
        cnt_reg <= cnt_end ? bi.reload : RELOAD_W'(cnt_reg - 1'b1);
    end
  end

  assign bi.tick = tick_reg;

  // tick spacing checker
  logic [15:0] gap_reg;
  logic        seen_reg;
  logic [RELOAD_W:0] cfg_reg;
  wire  [15:0] period = 16'((bi.presc ? 16'h3 : 16'h2) * (16'(bi.reload) + 16'h1));
  wire         chg    = (cfg_reg != {bi.presc, bi.reload}) | ~bi.run;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gap_reg  <= 16'h0;
      seen_reg <= 1'b0;
      cfg_reg  <= '0;
    end
    else
    begin
      cfg_reg  <= {bi.presc, bi.reload};
      gap_reg  <= tick_reg ? 16'h1 : 16'(gap_reg + 16'h1);
      seen_reg <= chg ? 1'b0 : (seen_reg | tick_reg);
    end
  end

  property p_tick_period;
    @(posedge clk) disable iff (!rst_n)
      (tick_reg && seen_reg && !chg) |-> (gap_reg == period);
  endproperty
  a_tick_period: assert property (p_tick_period) // R01
    else $error("baud tick spacing wrong");
endmodule

/* assc_baud_if.sv */
// link between channel and its baud generator
interface assc_baud_if #(
  parameter int W = 13
);
  logic         run;
  logic         presc;
  logic [W-1:0] reload;
  logic         tick;
  modport gen (
    input  run,
    input  presc,
    input  reload,
    output tick
  );
  modport use_side (
    output run,
    output presc,
    output reload,
    input  tick
  );
endinterface

/* assc_channel.sv */
// serial channel top: apb registers, transmitter, receiver, interrupts
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`include "assc_defines.svh"

// How it works
// [R01] bit lasts 32 or 48 times reload+1
// [R02] separate transmit, receive and error requests
// [R03] start, 8 or 9 bits, 1-2 stops
// [R04] ninth bit carries address/data wake flag
// [R05] sync mode shifts bytes on own clock
// [R06] least significant bit shifted first
// [R07] loopback feeds transmitter into receiver
// [R08] parity generated on send, checked on receive
// [R09] low stop bit flags framing error
// [R10] unread buffer at completion flags overrun
// [R11] each error check enabled separately
// [R12] errors sticky, raise error request until cleared
// [R13] start bit confirmed low at its middle
module assc_channel
  import assc_pkg::*;
#(
  parameter int RELOAD_W = `ASSC_RELOAD_W
)
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`ASSC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                         txd_out,
  input  wire logic                    rxd_in,
  output logic                         rxd_out,
  output logic                         rxd_oe,
  output logic                         irq,
  output logic                         irq_tx,
  output logic                         irq_rx,
  output logic                         irq_err
);
  logic [`ASSC_CTRL_W-1:0] ctrl_reg;
  logic [RELOAD_W-1:0]     reload_reg;
  logic [`ASSC_EV_W-1:0]   ien_reg;
  logic [`ASSC_EV_W-1:0]   stat_reg;
  logic [`ASSC_EV_W-1:0]   stat_next;
  logic [`ASSC_EV_W-1:0]   ev_set;
  logic [`ASSC_EV_W-1:0]   ev_clr;
  logic [8:0]              tx_hold_reg;
  logic                    tx_hold_full_reg;
  logic [8:0]              rx_buf_reg;
  logic                    rx_full_reg;
  logic [31:0]             prdata_reg;
  logic                    pready_reg;
  logic                    pslverr_reg;
  logic                    txd_reg;
  logic                    rxd_out_reg;
  logic                    rxd_oe_reg;
  logic                    irq_reg;
  logic                    irq_tx_reg;
  logic                    irq_rx_reg;
  logic                    irq_err_reg;
  assc_tx_state_t          tx_state_reg;
  assc_tx_state_t          tx_state_next;
  logic [3:0]              tx_tick_reg;
  logic [3:0]              tx_bit_reg;
  logic [8:0]              tx_shift_reg;
  logic                    tx_stop2_reg;
  assc_rx_state_t          rx_state_reg;
  assc_rx_state_t          rx_state_next;
  logic [3:0]              rx_tick_reg;
  logic [3:0]              rx_bit_reg;
  logic [8:0]              rx_shift_reg;
  assc_mode_t              mode;

  function automatic logic par_of(input logic [7:0] d, input logic odd);
    return (^d) ^ odd;
  endfunction

  // baud generator
  assc_baud_if #(.W(RELOAD_W)) baud ();
  assc_baud_gen #(.RELOAD_W(RELOAD_W)) u_baud (
    .clk   (clk),
    .rst_n (rst_n),
    .bi    (baud.gen)
  );
  assign baud.run    = ctrl_reg[`ASSC_B_RUN];
  assign baud.presc  = ctrl_reg[`ASSC_B_PRESC]; // R01
  assign baud.reload = reload_reg;
  wire tick = baud.tick;

  // bus decode
  wire setup    = psel & ~penable;
  wire wr       = psel & penable & pwrite;
  wire rd       = psel & penable & ~pwrite;
  wire sel_ctrl = (paddr == `ASSC_OFF_CTRL);
  wire sel_baud = (paddr == `ASSC_OFF_BAUD);
  wire sel_txd  = (paddr == `ASSC_OFF_TXD);
  wire sel_rxd  = (paddr == `ASSC_OFF_RXD);
  wire sel_stat = (paddr == `ASSC_OFF_STAT);
  wire sel_clr  = (paddr == `ASSC_OFF_CLR);
  wire sel_ien  = (paddr == `ASSC_OFF_IEN);
  wire mapped   = sel_ctrl | sel_baud | sel_txd | sel_rxd | sel_stat | sel_clr | sel_ien;
  wire rx_read  = rd & sel_rxd;
  wire tx_wr    = wr & sel_txd & ~tx_hold_full_reg;

  // mode decode
  assign mode   = assc_mode_t'(ctrl_reg[`ASSC_B_MODE_HI:`ASSC_B_MODE_LO]);
  wire run      = ctrl_reg[`ASSC_B_RUN];
  wire sync_m   = (mode == ASSC_MODE_SYNC);
  wire nine     = (mode == ASSC_MODE_A9) | (mode == ASSC_MODE_WAKE); // R03
  wire par_on   = ctrl_reg[`ASSC_B_PAREN] & (mode == ASSC_MODE_A9); // R11
  wire par_odd  = ctrl_reg[`ASSC_B_PARODD];
  wire tx_busy  = (tx_state_reg != ASSC_TX_IDLE);
  wire [10:0] stat_rd = {tx_hold_full_reg, rx_full_reg, tx_busy, 3'h0, stat_reg};

  wire [31:0] rdata_mux =
    sel_ctrl ? 32'(ctrl_reg)   :
    sel_baud ? 32'(reload_reg) :
    sel_txd  ? 32'(tx_hold_reg) :
    sel_rxd  ? 32'(rx_buf_reg) :
    sel_stat ? 32'(stat_rd)    :
    sel_ien  ? 32'(ien_reg)    : 32'h0;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg <= 1'b1;
      if (setup)
      begin
        prdata_reg  <= pwrite ? 32'h0 : rdata_mux;
        pslverr_reg <= ~mapped;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg   <= `ASSC_CTRL_RST;
      reload_reg <= '0;
      ien_reg    <= '0;
    end
    else if (wr)
    begin
      if (sel_ctrl)
        ctrl_reg <= pwdata[`ASSC_CTRL_W-1:0];
      if (sel_baud)
        reload_reg <= pwdata[RELOAD_W-1:0];
      if (sel_ien)
        ien_reg <= pwdata[`ASSC_EV_W-1:0];
    end
  end

  // transmitter
  wire tx_bit_end  = tick & (tx_tick_reg == `ASSC_TICK_LAST);
  wire tx_last_bit = (tx_bit_reg == `ASSC_BIT_LAST);
  wire tx_go       = run & ~tx_busy & tx_hold_full_reg;
  wire tx_ninth    = par_on ? par_of(tx_hold_reg[7:0], par_odd) : tx_hold_reg[8]; // R08
  wire tx_stop_end = (tx_state_reg == ASSC_TX_STOP)
                   & (~ctrl_reg[`ASSC_B_STOP2] | tx_stop2_reg); // R03
  wire tx_sync_end = (tx_state_reg == ASSC_TX_DATA) & sync_m & tx_last_bit;
  wire tx_done     = tx_bit_end & (tx_stop_end | tx_sync_end);

  always_comb
  begin
    tx_state_next = tx_state_reg;
    unique case (tx_state_reg)
      ASSC_TX_IDLE:
        if (tx_go)
          tx_state_next = sync_m ? ASSC_TX_DATA : ASSC_TX_START; // R05
      ASSC_TX_START:
        if (tx_bit_end)
          tx_state_next = ASSC_TX_DATA;
      ASSC_TX_DATA:
        if (tx_bit_end && tx_last_bit)
          tx_state_next = sync_m ? ASSC_TX_IDLE : (nine ? ASSC_TX_NINTH : ASSC_TX_STOP);
      ASSC_TX_NINTH:
        if (tx_bit_end)
          tx_state_next = ASSC_TX_STOP;
      ASSC_TX_STOP:
        if (tx_done)
          tx_state_next = ASSC_TX_IDLE;
      default:
        tx_state_next = ASSC_TX_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= ASSC_TX_IDLE;
      tx_tick_reg  <= `ASSC_TICK_ZERO;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 9'h1ff;
      tx_stop2_reg <= 1'b0;
    end
    else if (!run)
      tx_state_reg <= ASSC_TX_IDLE;
    else
    begin
      tx_state_reg <= tx_state_next;
      if (tx_go)
      begin
        tx_tick_reg  <= `ASSC_TICK_ZERO;
        tx_bit_reg   <= 4'h0;
        tx_shift_reg <= {tx_ninth, tx_hold_reg[7:0]}; // R04
        tx_stop2_reg <= 1'b0;
      end
      else
      begin
        if (tick)
          tx_tick_reg <= 4'(tx_tick_reg + 4'h1);
        if (tx_bit_end && tx_state_reg == ASSC_TX_DATA)
        begin
          tx_shift_reg <= {1'b1, tx_shift_reg[8:1]}; // R06
          tx_bit_reg   <= 4'(tx_bit_reg + 4'h1);
        end
        if (tx_bit_end && tx_state_reg == ASSC_TX_STOP)
          tx_stop2_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_hold_reg      <= 9'h000;
      tx_hold_full_reg <= 1'b0;
    end
    else
    begin
      if (tx_wr)
        tx_hold_reg <= pwdata[8:0];
      tx_hold_full_reg <= tx_wr | (tx_hold_full_reg & ~tx_go);
    end
  end

  // pin drive
  wire tx_in_bits = (tx_state_reg == ASSC_TX_DATA) | (tx_state_reg == ASSC_TX_NINTH);
  wire async_line = (tx_state_reg == ASSC_TX_START) ? 1'b0 :
                    tx_in_bits ? tx_shift_reg[0] : 1'b1;
  wire sclk       = (tx_state_reg != ASSC_TX_DATA) | tx_tick_reg[3]; // R05
  wire rx_en      = ctrl_reg[`ASSC_B_RXEN];
  wire txd_next   = sync_m ? sclk : async_line;
  wire rxd_o_next = sync_m ? tx_shift_reg[0] : 1'b1;
  wire rxd_e_next = sync_m & (tx_state_reg == ASSC_TX_DATA) & ~rx_en;

  // receiver
  wire rx_line  = ctrl_reg[`ASSC_B_LOOP] ?
                  (sync_m ? tx_shift_reg[0] : txd_reg) : rxd_in; // R07
  wire rx_on    = run & rx_en & ~sync_m;
  wire rx_samp  = tick & (rx_tick_reg == `ASSC_TICK_LAST);
  wire rx_mid   = tick & (rx_tick_reg == `ASSC_TICK_MID);
  wire sync_smp = sync_m & rx_en & (tx_state_reg == ASSC_TX_DATA)
                & tick & (tx_tick_reg == `ASSC_TICK_MID);
  wire rx_bits  = (rx_state_reg == ASSC_RX_DATA) | (rx_state_reg == ASSC_RX_NINTH);

  always_comb
  begin
    rx_state_next = rx_state_reg;
    unique case (rx_state_reg)
      ASSC_RX_IDLE:
        if (!rx_line)
          rx_state_next = ASSC_RX_START;
      ASSC_RX_START:
        if (rx_mid)
          rx_state_next = rx_line ? ASSC_RX_IDLE : ASSC_RX_DATA; // R13
      ASSC_RX_DATA:
        if (rx_samp && rx_bit_reg == `ASSC_BIT_LAST)
          rx_state_next = nine ? ASSC_RX_NINTH : ASSC_RX_STOP;
      ASSC_RX_NINTH:
        if (rx_samp)
          rx_state_next = ASSC_RX_STOP;
      ASSC_RX_STOP:
        if (rx_samp)
          rx_state_next = ASSC_RX_IDLE;
      default:
        rx_state_next = ASSC_RX_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rx_state_reg <= ASSC_RX_IDLE;
      rx_tick_reg  <= `ASSC_TICK_ZERO;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
    end
    else if (!rx_on)
    begin
      rx_state_reg <= ASSC_RX_IDLE;
      rx_tick_reg  <= `ASSC_TICK_ZERO;
      if (sync_smp)
        rx_shift_reg <= {rx_line, rx_shift_reg[8:1]}; // R06
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      if (rx_state_reg == ASSC_RX_IDLE || (rx_mid && rx_state_reg == ASSC_RX_START))
        rx_tick_reg <= `ASSC_TICK_ZERO; // R13
      else if (tick)
        rx_tick_reg <= 4'(rx_tick_reg + 4'h1);
      if (rx_state_reg == ASSC_RX_START)
        rx_bit_reg <= 4'h0;
      if (rx_samp && rx_bits)
        rx_shift_reg <= {rx_line, rx_shift_reg[8:1]}; // R06
      if (rx_samp && rx_state_reg == ASSC_RX_DATA)
        rx_bit_reg <= 4'(rx_bit_reg + 4'h1);
    end
  end

  // completion and error events
  wire       frame_end = rx_on & rx_samp & (rx_state_reg == ASSC_RX_STOP);
  wire       sync_end  = tx_done & sync_m & rx_en;
  wire [8:0] rx_word   = nine ? rx_shift_reg : {1'b0, rx_shift_reg[8:1]};
  wire       rx_drop   = (mode == ASSC_MODE_WAKE) & ctrl_reg[`ASSC_B_WAKEF] & ~rx_word[8]; // R04
  wire       rx_store  = (frame_end | sync_end) & ~rx_drop;
  wire       par_bad   = par_on & (rx_word[8] != par_of(rx_word[7:0], par_odd)); // R08
  wire       frm_bad   = ctrl_reg[`ASSC_B_FRMEN] & frame_end & ~rx_line; // R09
  wire       ovr_bad   = ctrl_reg[`ASSC_B_OVREN] & rx_full_reg & ~rx_read; // R10

  assign ev_set[`ASSC_EV_TX]  = tx_done;
  assign ev_set[`ASSC_EV_RX]  = rx_store;
  assign ev_set[`ASSC_EV_PAR] = rx_store & par_bad;
  assign ev_set[`ASSC_EV_FRM] = rx_store & frm_bad;
  assign ev_set[`ASSC_EV_OVR] = rx_store & ovr_bad;
  assign ev_clr    = (wr & sel_clr) ? pwdata[`ASSC_EV_W-1:0] : '0;
  assign stat_next = (stat_reg & ~ev_clr) | ev_set; // R12

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stat_reg    <= '0;
      rx_buf_reg  <= 9'h000;
      rx_full_reg <= 1'b0;
    end
    else
    begin
      stat_reg <= stat_next;
      if (rx_store)
        rx_buf_reg <= rx_word;
      rx_full_reg <= rx_store | (rx_full_reg & ~rx_read);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      txd_reg     <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg  <= 1'b0;
      irq_reg     <= 1'b0;
      irq_tx_reg  <= 1'b0;
      irq_rx_reg  <= 1'b0;
      irq_err_reg <= 1'b0;
    end
    else
    begin
      txd_reg     <= txd_next;
      rxd_out_reg <= rxd_o_next;
      rxd_oe_reg  <= rxd_e_next;
      irq_reg     <= |(stat_reg & ien_reg);
      irq_tx_reg  <= stat_reg[`ASSC_EV_TX] & ien_reg[`ASSC_EV_TX]; // R02
      irq_rx_reg  <= stat_reg[`ASSC_EV_RX] & ien_reg[`ASSC_EV_RX]; // R02
      irq_err_reg <= |(stat_reg[`ASSC_EV_OVR:`ASSC_EV_PAR]
                       & ien_reg[`ASSC_EV_OVR:`ASSC_EV_PAR]); // R12
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;
  assign txd_out = txd_reg;
  assign rxd_out = rxd_out_reg;
  assign rxd_oe  = rxd_oe_reg;
  assign irq     = irq_reg;
  assign irq_tx  = irq_tx_reg;
  assign irq_rx  = irq_rx_reg;
  assign irq_err = irq_err_reg;

  property p_tx_irq;
    @(posedge clk) disable iff (!rst_n)
      (tx_done && ien_reg[`ASSC_EV_TX] && !ev_clr[`ASSC_EV_TX] && !(wr && sel_ien))
      |=> ##1 irq_tx;
  endproperty
  a_tx_irq: assert property (p_tx_irq) // R02
    else $error("transmit request missing");

  property p_stop_high;
    @(posedge clk) disable iff (!rst_n)
      (run && !sync_m && tx_state_reg == ASSC_TX_STOP) |=> txd_out;
  endproperty
  a_stop_high: assert property (p_stop_high) // R03
    else $error("stop bit not high");

  property p_start_low;
    @(posedge clk) disable iff (!rst_n)
      (tx_go && !sync_m) |=> ##1 !txd_out;
  endproperty
  a_start_low: assert property (p_start_low) // R03
    else $error("start bit not low");

  property p_wake_bit;
    @(posedge clk) disable iff (!rst_n)
      (tx_go && mode == ASSC_MODE_WAKE) |=> tx_shift_reg[8] == $past(tx_hold_reg[8]);
  endproperty
  a_wake_bit: assert property (p_wake_bit) // R04
    else $error("wake bit not loaded");

  property p_sync_clk;
    @(posedge clk) disable iff (!rst_n)
      (run && sync_m && tx_state_reg == ASSC_TX_DATA && !tx_tick_reg[3]) |=> !txd_out;
  endproperty
  a_sync_clk: assert property (p_sync_clk) // R05
    else $error("shift clock not low");

  property p_lsb_first;
    @(posedge clk) disable iff (!rst_n)
      (run && !tx_go && tx_bit_end && tx_state_reg == ASSC_TX_DATA)
      |=> tx_shift_reg[7:0] == $past(tx_shift_reg[8:1]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) // R06
    else $error("shift direction wrong");

  property p_tx_parity;
    @(posedge clk) disable iff (!rst_n)
      (tx_go && par_on) |=> (^tx_shift_reg) == $past(par_odd);
  endproperty
  a_tx_parity: assert property (p_tx_parity) // R08
    else $error("parity bit wrong");

  property p_frame_err;
    @(posedge clk) disable iff (!rst_n)
      (rx_store && frm_bad && ien_reg[`ASSC_EV_FRM] && !(wr && sel_ien))
      |=> stat_reg[`ASSC_EV_FRM] ##1 irq_err;
  endproperty
  a_frame_err: assert property (p_frame_err) // R09
    else $error("framing error not flagged");

  property p_overrun;
    @(posedge clk) disable iff (!rst_n)
      (rx_store && rx_full_reg && !rx_read && ctrl_reg[`ASSC_B_OVREN])
      |=> stat_reg[`ASSC_EV_OVR] && rx_full_reg;
  endproperty
  a_overrun: assert property (p_overrun) // R10
    else $error("overrun not flagged");

  property p_err_sticky;
    @(posedge clk) disable iff (!rst_n)
      (stat_reg[`ASSC_EV_PAR] && !ev_clr[`ASSC_EV_PAR]) |=> stat_reg[`ASSC_EV_PAR];
  endproperty
  a_err_sticky: assert property (p_err_sticky) // R12
    else $error("error flag lost");

  property p_false_start;
    @(posedge clk) disable iff (!rst_n)
      (rx_on && rx_state_reg == ASSC_RX_START && rx_mid && rx_line) |=> rx_state_reg == ASSC_RX_IDLE;
  endproperty
  a_false_start: assert property (p_false_start) // R13
    else $error("false start accepted");
endmodule

/* assc_defines.svh */
// register map, field positions and timing counts of the serial channel
`ifndef ASSC_DEFINES_SVH
`define ASSC_DEFINES_SVH
`define ASSC_RELOAD_W 13
`define ASSC_ADDR_W 8
`define ASSC_OFF_CTRL 8'h00
`define ASSC_OFF_BAUD 8'h04
`define ASSC_OFF_TXD 8'h08
`define ASSC_OFF_RXD 8'h0c
`define ASSC_OFF_STAT 8'h10
`define ASSC_OFF_CLR 8'h14
`define ASSC_OFF_IEN 8'h18
`define ASSC_CTRL_W 12
`define ASSC_CTRL_RST 12'h000
`define ASSC_B_RUN 0
`define ASSC_B_MODE_LO 1
`define ASSC_B_MODE_HI 2
`define ASSC_B_STOP2 3
`define ASSC_B_PAREN 4
`define ASSC_B_PARODD 5
`define ASSC_B_FRMEN 6
`define ASSC_B_OVREN 7
`define ASSC_B_LOOP 8
`define ASSC_B_RXEN 9
`define ASSC_B_PRESC 10
`define ASSC_B_WAKEF 11
`define ASSC_EV_W 5
`define ASSC_EV_TX 0
`define ASSC_EV_RX 1
`define ASSC_EV_PAR 2
`define ASSC_EV_FRM 3
`define ASSC_EV_OVR 4
`define ASSC_TICK_ZERO 4'h0
`define ASSC_TICK_MID 4'h7
`define ASSC_TICK_LAST 4'hf
`define ASSC_BIT_LAST 4'h7
`define ASSC_PRE_2 2'h1
`define ASSC_PRE_3 2'h2
`endif

/* assc_pkg.sv */
// types of the serial channel
package assc_pkg;
  typedef enum logic [1:0] {
    ASSC_MODE_A8   = 2'h0,
    ASSC_MODE_A9   = 2'h1,
    ASSC_MODE_WAKE = 2'h2,
    ASSC_MODE_SYNC = 2'h3
  } assc_mode_t;
  typedef enum logic [2:0] {
    ASSC_TX_IDLE  = 3'h0,
    ASSC_TX_START = 3'h1,
    ASSC_TX_DATA  = 3'h2,
    ASSC_TX_NINTH = 3'h3,
    ASSC_TX_STOP  = 3'h4
  } assc_tx_state_t;
  typedef enum logic [2:0] {
    ASSC_RX_IDLE  = 3'h0,
    ASSC_RX_START = 3'h1,
    ASSC_RX_DATA  = 3'h2,
    ASSC_RX_NINTH = 3'h3,
    ASSC_RX_STOP  = 3'h4
  } assc_rx_state_t;
endpackage

/* assc_remote_peer.sv */
// remote serial partner: async frame sender, 8-bit receiver, sync capture
module assc_remote_peer (
  input  wire logic        clk,
  input  wire logic        from_dev,
  output logic             to_dev,
  input  wire logic [31:0] bit_clks,
  input  wire logic        data_in,
  input  wire logic        data_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rx_byte;
  logic [7:0] sync_byte;
  int         rx_count;
  initial
  begin
    to_dev = 1'b1;
    rx_byte = 8'h00;
    rx_count = 0;
  end
  // sync mode: data pin taken at shift clock rise, lsb first
  always @(posedge from_dev)
    if (data_oe)
      sync_byte <= {data_in, sync_byte[7:1]};
  // start, lsb first data, stop, then idle high
  task automatic send(input logic [8:0] d, input int nbits, input logic stop);
    to_dev <= 1'b0;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < nbits; i++)
    begin
      to_dev <= d[i];
      repeat (bit_clks) @(posedge clk);
    end
    to_dev <= stop;
    repeat (stop ? bit_clks : bit_clks * 5 / 8) @(posedge clk);
    to_dev <= 1'b1;
    repeat (bit_clks) @(posedge clk);
  endtask
  always
  begin
    @(negedge from_dev);
    repeat (bit_clks / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bit_clks) @(posedge clk);
      rx_byte[i] = from_dev;
    end
    repeat (bit_clks) @(posedge clk);
    rx_count++;
  end
endmodule

/* test_async_sync_serial_channel.sv */
// self-checking bench of the serial channel
`include "assc_defines.svh"

module test_async_sync_serial_channel;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic err;} assc_row_t;
  assc_row_t   rows [12];
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, rerr, txd_out, rxd_in, rxd_out, rxd_oe;
  logic        irq, irq_tx, irq_rx, irq_err, peer_line;
  int          peer_bit = 32;
  int          n_fail = 0;
  int          tests_run = 0;

  always #5 clk = ~clk;
  assign rxd_in = rxd_oe ? rxd_out : peer_line;

  assc_channel i_dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .txd_out(txd_out), .rxd_in(rxd_in), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .irq(irq), .irq_tx(irq_tx), .irq_rx(irq_rx), .irq_err(irq_err)
  );
  assc_remote_peer i_peer (
    .clk(clk), .from_dev(txd_out), .to_dev(peer_line), .bit_clks(peer_bit),
    .data_in(rxd_out), .data_oe(rxd_oe)
  );

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic stat(input logic [4:0] exp);
    apb(1'b0, `ASSC_OFF_STAT, 32'h0);
    chk("status", {27'h0, exp}, rd & 32'h1f);
  endtask
  task automatic wait_stat(input int b);
    repeat (3000)
    begin
      apb(1'b0, `ASSC_OFF_STAT, 32'h0);
      if (rd[b] === 1'b1) break;
    end
    repeat (3) @(posedge clk);
  endtask
  task automatic clr();
    apb(1'b1, `ASSC_OFF_CLR, 32'h1f);
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (50000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial
  begin
    rows = '{
      '{1'b0, `ASSC_OFF_CTRL, 32'h0, 1'b0}, '{1'b0, `ASSC_OFF_STAT, 32'h0, 1'b0},
      '{1'b1, `ASSC_OFF_CTRL, 32'hfff, 1'b0}, '{1'b0, `ASSC_OFF_CTRL, 32'hfff, 1'b0},
      '{1'b1, `ASSC_OFF_CTRL, 32'h0, 1'b0}, '{1'b1, `ASSC_OFF_BAUD, 32'h1fff, 1'b0},
      '{1'b0, `ASSC_OFF_BAUD, 32'h1fff, 1'b0}, '{1'b1, `ASSC_OFF_BAUD, 32'h0, 1'b0},
      '{1'b0, `ASSC_OFF_CLR, 32'h0, 1'b0}, '{1'b1, `ASSC_OFF_IEN, 32'h1f, 1'b0},
      '{1'b0, `ASSC_OFF_IEN, 32'h1f, 1'b0}, '{1'b0, 8'h1c, 32'h0, 1'b1}};
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    chk("irq reset", 32'h0, {31'h0, irq});
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk("register", rows[i].d, rd);
      chk("pslverr", {31'h0, rows[i].err}, {31'h0, rerr});
    end
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'b1, `ASSC_OFF_CTRL, 32'h001);
    apb(1'b1, `ASSC_OFF_TXD, 32'h0a5);
    wait_stat(0);
    chk("tx byte", 32'ha5, {24'h0, i_peer.rx_byte});
    chk("irq_tx", 32'h1, {31'h0, irq_tx});
    clr();
    peer_bit = 48;
    apb(1'b1, `ASSC_OFF_CTRL, 32'h401);
    apb(1'b1, `ASSC_OFF_TXD, 32'h03c);
    wait_stat(0);
    chk("prescaled byte", 32'h3c, {24'h0, i_peer.rx_byte});
    peer_bit = 32;
    apb(1'b1, `ASSC_OFF_CTRL, 32'h2d3);
    clr();
    i_peer.send(9'h05a, 9, 1'b1);
    stat(5'h02);
    chk("irq_rx", 32'h1, {31'h0, irq_rx});
    apb(1'b0, `ASSC_OFF_RXD, 32'h0);
    chk("rx byte", 32'h5a, rd & 32'hff);
    clr();
    i_peer.send(9'h15a, 9, 1'b1);
    stat(5'h06);
    chk("irq_err", 32'h3, {30'h0, irq_err, irq});
    clr();
    repeat (3) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b0, `ASSC_OFF_RXD, 32'h0);
    clr();
    i_peer.send(9'h05a, 9, 1'b0);
    stat(5'h0a);
    clr();
    i_peer.send(9'h05a, 9, 1'b1);
    stat(5'h12);
    apb(1'b1, `ASSC_OFF_CTRL, 32'h203);
    clr();
    i_peer.send(9'h05a, 9, 1'b0);
    stat(5'h02);
    apb(1'b1, `ASSC_OFF_CTRL, 32'ha05);
    apb(1'b0, `ASSC_OFF_RXD, 32'h0);
    clr();
    i_peer.send(9'h055, 9, 1'b1);
    stat(5'h00);
    i_peer.send(9'h1aa, 9, 1'b1);
    stat(5'h02);
    apb(1'b0, `ASSC_OFF_RXD, 32'h0);
    chk("wake rx", 32'h1aa, rd & 32'h1ff);
    apb(1'b1, `ASSC_OFF_CTRL, 32'h301);
    clr();
    apb(1'b1, `ASSC_OFF_TXD, 32'h096);
    wait_stat(1);
    apb(1'b0, `ASSC_OFF_RXD, 32'h0);
    chk("loopback", 32'h96, rd & 32'hff);
    apb(1'b1, `ASSC_OFF_CTRL, 32'h333);
    clr();
    apb(1'b1, `ASSC_OFF_TXD, 32'h0a5);
    wait_stat(1);
    chk("odd parity", 32'h0, {31'h0, rd[`ASSC_EV_PAR]});
    apb(1'b0, `ASSC_OFF_RXD, 32'h0);
    chk("parity tx", 32'h1a5, rd & 32'h1ff);
    apb(1'b1, `ASSC_OFF_CTRL, 32'h30d);
    clr();
    apb(1'b1, `ASSC_OFF_TXD, 32'h1a5);
    wait_stat(1);
    repeat (24) @(posedge clk);
    apb(1'b0, `ASSC_OFF_STAT, 32'h0);
    chk("second stop", 32'h1, {31'h0, rd[8]});
    apb(1'b0, `ASSC_OFF_RXD, 32'h0);
    chk("wake tx", 32'h1a5, rd & 32'h1ff);
    clr();
    wait_stat(0);
    apb(1'b1, `ASSC_OFF_CTRL, 32'h007);
    clr();
    apb(1'b1, `ASSC_OFF_TXD, 32'h069);
    wait_stat(0);
    chk("sync tx", 32'h69, {24'h0, i_peer.sync_byte});
    apb(1'b1, `ASSC_OFF_CTRL, 32'h307);
    clr();
    apb(1'b1, `ASSC_OFF_TXD, 32'h0c3);
    wait_stat(1);
    apb(1'b0, `ASSC_OFF_RXD, 32'h0);
    chk("sync loopback", 32'hc3, rd & 32'hff);
    complete_run();
  end
endmodule
